/* design/nv_host_pkg.sv */
package nv_host_pkg;
  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int TIMER_W = 20;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int SETUP_NS = 10;
  localparam int STROBE_NS = 60;
  localparam int HOLD_NS = 10;
  localparam int RECALL_MAX_US = 5;
  localparam int STORE_MAX_MS = 5;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECALL_CYC = (RECALL_MAX_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STORE_CYC_DEFAULT = (STORE_MAX_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------------
  // Command sequence
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CMD_ADDR_A = 9'h155;
  localparam logic [ADDR_W-1:0] CMD_ADDR_B = 9'h0AA;
  localparam logic [DATA_W-1:0] CMD_DATA_1 = 8'hAA;
  localparam logic [DATA_W-1:0] CMD_DATA_2 = 8'h55;
  localparam logic [DATA_W-1:0] CMD_DATA_STORE = 8'h33;
  localparam logic [DATA_W-1:0] CMD_DATA_SAVE_ON = 8'hCC;
  localparam logic [DATA_W-1:0] CMD_DATA_SAVE_OFF = 8'hCD;
  localparam logic [1:0] STEP_FIRST = 2'h0;
  localparam logic [1:0] STEP_SECOND = 2'h1;
  localparam logic [1:0] STEP_LAST = 2'h2;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_RECALL = 3'h2,
    OP_STORE = 3'h3,
    OP_SAVE_ON = 3'h4,
    OP_SAVE_OFF = 3'h5
  } op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_STROBE = 3'h3,
    ST_HOLD = 3'h2,
    ST_WAIT = 3'h6
  } state_e;
endpackage

/* design/phase_timer_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface phase_timer_if;
  logic load;
  logic [nv_host_pkg::TIMER_W-1:0] count;
  logic done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface
`default_nettype wire

/* design/phase_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module phase_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  phase_timer_if.tmr tif
);
  import nv_host_pkg::*;

  typedef struct packed {
    logic [TIMER_W-1:0] cnt;
  } timer_s;

  timer_s r, n;

  always_comb begin
    n = r;
    if (tif.load) begin
      n.cnt = tif.count;
    end else if (r.cnt != '0) begin
      n.cnt = r.cnt - TIMER_W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tif.done = (r.cnt == '0);
endmodule // phase_timer
`default_nettype wire

/* design/nv_host_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Chip select low for every access.
// - Commands are strobed pseudo writes.
// - Store sequence AA, 55, 33.
// - Final 155h/CCh enables power-loss save.
// - Final 155h/CDh disables power-loss save.
module nv_host_ctrl #(
  parameter int STORE_WAIT_CYC = nv_host_pkg::STORE_CYC_DEFAULT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // User command port
  input wire logic cmd_valid,
  input wire nv_host_pkg::op_e cmd_op,
  input wire logic [nv_host_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [nv_host_pkg::DATA_W-1:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [nv_host_pkg::DATA_W-1:0] rsp_rdata,
  // Status
  output logic save_enabled,
  output logic ram_written,
  output logic power_fail_alert,
  // Device pins
  output logic chip_select_n,
  output logic output_enable_n,
  output logic write_enable_n,
  output logic nonvolatile_select_n,
  output logic [nv_host_pkg::ADDR_W-1:0] byte_address,
  output logic [nv_host_pkg::DATA_W-1:0] data_bus_o,
  output logic data_bus_oe,
  input wire logic [nv_host_pkg::DATA_W-1:0] data_bus_i,
  input wire logic power_fail_flag_n
);
  import nv_host_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    state_e st;
    logic [1:0] step;
    op_e op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic ne_n;
    logic d_oe;
    logic [ADDR_W-1:0] pin_addr;
    logic [DATA_W-1:0] pin_data;
    logic [DATA_W-1:0] rdata;
    logic rsp;
    logic ready;
    logic written;
    logic save_on;
    logic pfail;
  } ctrl_s;

  ctrl_s r, n;
  phase_timer_if tif ();

  phase_timer u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .tif(tif)
  );

  // ------------------------------------------------------------------
  // Sequencing
  // ------------------------------------------------------------------
  always_comb begin
    logic multi;
    logic [DATA_W-1:0] last_data;
    multi = 1'b0;
    last_data = CMD_DATA_STORE;
    n = r;
    n.rsp = 1'b0;
    n.pfail = !power_fail_flag_n;
    tif.load = 1'b0;
    tif.count = '0;
    multi = (r.op == OP_STORE) || (r.op == OP_SAVE_ON) || (r.op == OP_SAVE_OFF);
    case (r.op)
      OP_SAVE_ON: begin
        last_data = CMD_DATA_SAVE_ON;
      end
      OP_SAVE_OFF: begin
        last_data = CMD_DATA_SAVE_OFF;
      end
      default: begin
        last_data = CMD_DATA_STORE;
      end
    endcase
    case (r.st)
      ST_IDLE: begin
        n.ready = 1'b1;
        if (cmd_valid && r.ready) begin
          n.ready = 1'b0;
          n.op = cmd_op;
          n.addr = cmd_addr;
          n.wdata = cmd_wdata;
          n.step = STEP_FIRST;
          n.st = ST_SETUP;
          tif.load = 1'b1;
          tif.count = TIMER_W'(SETUP_CYC - 1);
        end
      end
      ST_SETUP: begin
        if (multi) begin
          n.pin_addr = (r.step == STEP_SECOND) ? CMD_ADDR_B : CMD_ADDR_A;
          n.pin_data = (r.step == STEP_FIRST) ? CMD_DATA_1 :
                       (r.step == STEP_SECOND) ? CMD_DATA_2 : last_data;
        end else begin
          n.pin_addr = r.addr;
          n.pin_data = r.wdata;
        end
        n.d_oe = multi || (r.op == OP_WRITE);
        if (tif.done) begin
          n.st = ST_STROBE;
          n.ce_n = 1'b0;
          n.ne_n = !(multi || (r.op == OP_RECALL));
          n.we_n = !(multi || (r.op == OP_WRITE));
          n.oe_n = !((r.op == OP_READ) || (r.op == OP_RECALL));
          tif.load = 1'b1;
          tif.count = TIMER_W'(STROBE_CYC - 1);
        end
      end
      ST_STROBE: begin
        if (tif.done) begin
          if (r.op == OP_READ) begin
            n.rdata = data_bus_i;
          end
          n.ce_n = 1'b1;
          n.oe_n = 1'b1;
          n.we_n = 1'b1;
          n.ne_n = 1'b1;
          n.st = ST_HOLD;
          tif.load = 1'b1;
          tif.count = TIMER_W'(HOLD_CYC - 1);
        end
      end
      ST_HOLD: begin
        if (tif.done) begin
          n.d_oe = 1'b0;
          if (multi && (r.step != STEP_LAST)) begin
            n.step = r.step + 2'h1;
            n.st = ST_SETUP;
            tif.load = 1'b1;
            tif.count = TIMER_W'(SETUP_CYC - 1);
          end else if (r.op == OP_RECALL) begin
            n.st = ST_WAIT;
            tif.load = 1'b1;
            tif.count = TIMER_W'(RECALL_CYC - 1);
          end else if (r.op == OP_STORE) begin
            n.st = ST_WAIT;
            tif.load = 1'b1;
            tif.count = TIMER_W'(STORE_WAIT_CYC - 1);
          end else begin
            if (r.op == OP_WRITE) begin
              n.written = 1'b1;
            end
            if (r.op == OP_SAVE_ON) begin
              n.save_on = 1'b1;
            end
            if (r.op == OP_SAVE_OFF) begin
              n.save_on = 1'b0;
            end
            n.st = ST_IDLE;
            n.rsp = 1'b1;
            n.ready = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        if (tif.done) begin
          n.st = ST_IDLE;
          n.rsp = 1'b1;
          n.ready = 1'b1;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{st: ST_IDLE, step: STEP_FIRST, op: OP_READ, addr: '0, wdata: '0,
             ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, ne_n: 1'b1, d_oe: 1'b0,
             pin_addr: '0, pin_data: '0, rdata: '0, rsp: 1'b0, ready: 1'b0,
             written: 1'b0, save_on: 1'b0, pfail: 1'b0};
    end else begin
      r <= n;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign cmd_ready = r.ready;
  assign rsp_valid = r.rsp;
  assign rsp_rdata = r.rdata;
  assign save_enabled = r.save_on;
  assign ram_written = r.written;
  assign power_fail_alert = r.pfail;
  assign chip_select_n = r.ce_n;
  assign output_enable_n = r.oe_n;
  assign write_enable_n = r.we_n;
  assign nonvolatile_select_n = r.ne_n;
  assign byte_address = r.pin_addr;
  assign data_bus_o = r.pin_data;
  assign data_bus_oe = r.d_oe;
endmodule // nv_host_ctrl
`default_nettype wire

/* sim/nv_host_ctrl_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module nv_host_ctrl_checker #(
  parameter int STORE_WAIT_CYC = 20
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Command port
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic power_fail_alert,
  // Device pins
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic nonvolatile_select_n,
  input wire logic [7:0] data_bus_o,
  input wire logic data_bus_oe,
  input wire logic power_fail_flag_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------------
  // Recall duration counter
  // ------------------------------------------------------------------
  localparam logic [10:0] RECALL_LIMIT = 11'h44C;
  logic [10:0] recall_cnt_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      recall_cnt_r <= 11'h000;
    end else if (rsp_valid) begin
      recall_cnt_r <= 11'h000;
    end else if ((recall_cnt_r != 11'h000) || (!output_enable_n && !nonvolatile_select_n)) begin
      recall_cnt_r <= recall_cnt_r + 11'h001;
    end
  end
  a_no_clash: assert property (data_bus_oe |-> output_enable_n)
    else $error("Data driven in a read.");
  a_read_pins: assert property (!output_enable_n && nonvolatile_select_n |-> write_enable_n && !chip_select_n)
    else $error("Bad read strobes.");
  a_write_data: assert property (!write_enable_n && nonvolatile_select_n |-> data_bus_oe && !chip_select_n)
    else $error("Write without data.");
  a_store_oe: assert property (!nonvolatile_select_n && !write_enable_n |-> output_enable_n)
    else $error("Output enable in command.");
  a_take_once: assert property (cmd_valid && cmd_ready |=> !cmd_ready [*8])
    else $error("Ready after accept.");
  a_alert_lag: assert property (power_fail_alert == !$past(power_fail_flag_n))
    else $error("Alert does not follow flag.");
  a_recall_time: assert property (recall_cnt_r <= RECALL_LIMIT)
    else $error("Recall too long.");
  a_store_time: assert property ($rose(write_enable_n) && !$past(nonvolatile_select_n)
    && data_bus_o == 8'h33 |-> ##[20:200] rsp_valid)
    else $error("Store wait wrong.");
endmodule // nv_host_ctrl_checker
bind nv_host_ctrl nv_host_ctrl_checker #(.STORE_WAIT_CYC(STORE_WAIT_CYC)) chk_i (.clock, .rst_n, .cmd_valid,
  .cmd_ready, .rsp_valid, .power_fail_alert, .chip_select_n, .output_enable_n, .write_enable_n,
  .nonvolatile_select_n, .data_bus_o, .data_bus_oe, .power_fail_flag_n);
`default_nettype wire

/* sim/nv_dev_model.sv */
`timescale 1ns/100ps
`default_nettype none
module nv_dev_model (
  // Strobes
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic nonvolatile_select_n,
  // Address and data
  input wire logic [8:0] byte_address,
  input wire logic [7:0] data_bus_o,
  input wire logic data_bus_oe,
  output logic [7:0] data_bus_i,
  // Supply
  input wire logic supply_low,
  output logic power_fail_flag_n
);
  logic [7:0] ram [512];
  logic [7:0] shadow [512];
  logic [8:0] la;
  logic [7:0] ld;
  logic lne, hit, written, save_on, drive;
  logic [1:0] step;
  int n_store;
  assign drive = !chip_select_n && !output_enable_n && write_enable_n && nonvolatile_select_n;
  assign data_bus_i = data_bus_oe ? data_bus_o : drive ? ram[byte_address] : ~data_bus_o;
  assign power_fail_flag_n = !supply_low;
  task automatic store();
    if (written && output_enable_n) begin
      for (int i = 0; i < 512; i++) shadow[i] = ram[i];
      n_store++;
    end
  endtask
  initial begin
    {written, save_on, hit, step, n_store} = '0;
    for (int i = 0; i < 512; i++) shadow[i] = 8'(i) ^ 8'h3C;
    for (int i = 0; i < 512; i++) ram[i] = shadow[i];
  end
  always @* if (!chip_select_n && !write_enable_n) {hit, lne, la, ld} = {1'h1, nonvolatile_select_n, byte_address,
    data_bus_i};
  always @(posedge write_enable_n) begin
    if (hit && lne) begin
      ram[la] = ld;
      written = 1'h1;
    end else if (hit) begin
      case ({step, la, ld})
        {2'h0, 9'h155, 8'hAA}: step = 2'h1;
        {2'h1, 9'h0AA, 8'h55}: step = 2'h2;
        {2'h2, 9'h155, 8'h33}: store();
        {2'h2, 9'h155, 8'hCC}: save_on = 1'h1;
        {2'h2, 9'h155, 8'hCD}: save_on = 1'h0;
        default: step = 2'h0;
      endcase
      if (step == 2'h2 && la == 9'h155) step = 2'h0;
    end
    hit = 1'h0;
  end
  always @(negedge output_enable_n or negedge chip_select_n or negedge nonvolatile_select_n) begin
    #1;
    if (!output_enable_n && !chip_select_n && !nonvolatile_select_n && write_enable_n)
      for (int i = 0; i < 512; i++) ram[i] = shadow[i];
  end
  always @(posedge supply_low) if (save_on) store();
endmodule // nv_dev_model
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  import nv_host_pkg::*;
  logic clock, rst_n, cmd_valid, cmd_ready, rsp_valid, save_enabled, ram_written, power_fail_alert, supply_low;
  logic chip_select_n, output_enable_n, write_enable_n, nonvolatile_select_n, data_bus_oe, power_fail_flag_n;
  logic [8:0] cmd_addr, byte_address;
  logic [7:0] cmd_wdata, rsp_rdata, data_bus_o, data_bus_i;
  op_e cmd_op;
  int n_errors, checked, cycles;
  nv_host_ctrl #(.STORE_WAIT_CYC(20)) dut (.clock, .rst_n, .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata, .cmd_ready,
    .rsp_valid, .rsp_rdata, .save_enabled, .ram_written, .power_fail_alert, .chip_select_n, .output_enable_n,
    .write_enable_n, .nonvolatile_select_n, .byte_address, .data_bus_o, .data_bus_oe, .data_bus_i, .power_fail_flag_n);
  nv_dev_model dev (.chip_select_n, .output_enable_n, .write_enable_n, .nonvolatile_select_n, .byte_address,
    .data_bus_o, .data_bus_oe, .data_bus_i, .supply_low, .power_fail_flag_n);
  always #2.5 clock = ~clock;
  task automatic summarize();
    $display("Errors %0d, checks %0d.", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic op(input op_e o, input logic [8:0] a, input logic [7:0] d);
    @(negedge clock);
    while (cmd_ready !== 1'h1) @(negedge clock);
    cmd_valid = 1'h1;
    cmd_op = o;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge clock);
    cmd_valid = 1'h0;
    while (rsp_valid !== 1'h1) @(negedge clock);
  endtask
  task automatic t_rw();
    op(OP_STORE, 9'h000, 8'h00);
    chk(8'(dev.n_store), 8'h00);
    chk({7'h00, ram_written}, 8'h00);
    op(OP_WRITE, 9'h000, 8'hA5);
    chk({7'h00, ram_written}, 8'h01);
    op(OP_WRITE, 9'h1FF, 8'h5A);
    op(OP_READ, 9'h1FF, 8'h00);
    chk(rsp_rdata, 8'h5A);
    op(OP_READ, 9'h000, 8'h00);
    chk(rsp_rdata, 8'hA5);
    op(OP_READ, 9'h0AA, 8'h00);
    chk(rsp_rdata, 8'h96);
    chk(dev.ram[9'h1FF], 8'h5A);
  endtask
  task automatic t_store_recall();
    op(OP_STORE, 9'h000, 8'h00);
    chk(8'(dev.n_store), 8'h01);
    chk(dev.shadow[9'h1FF], 8'h5A);
    op(OP_WRITE, 9'h1FF, 8'h00);
    op(OP_RECALL, 9'h000, 8'h00);
    op(OP_READ, 9'h1FF, 8'h00);
    chk(rsp_rdata, 8'h5A);
  endtask
  task automatic t_save();
    op(OP_SAVE_ON, 9'h000, 8'h00);
    chk({7'h00, save_enabled}, 8'h01);
    chk({7'h00, dev.save_on}, 8'h01);
    supply_low = 1'h1;
    repeat (2) @(negedge clock);
    chk({7'h00, power_fail_alert}, 8'h01);
    chk(8'(dev.n_store), 8'h02);
    supply_low = 1'h0;
    op(OP_SAVE_OFF, 9'h000, 8'h00);
    chk({7'h00, dev.save_on}, 8'h00);
    supply_low = 1'h1;
    repeat (2) @(negedge clock);
    chk(8'(dev.n_store), 8'h02);
    supply_low = 1'h0;
  endtask
  initial begin
    {clock, rst_n, cmd_valid, supply_low, cmd_addr, cmd_wdata} = '0;
    cmd_op = OP_READ;
    {n_errors, checked, cycles} = '0;
    repeat (10) @(negedge clock);
    rst_n = 1'h1;
    t_rw();
    t_store_recall();
    t_save();
    summarize();
  end
endmodule // tb
`default_nettype wire
